// *** shared/pwm_pkg.sv ***
// constants, register map and helper functions for the dual pwm block
// assumes a 25 MHz system clock and a 32-bit apb register port
package pwm_pkg;
  localparam int CNT_W = 10;
  localparam int CLK_HZ = 25000000;
  localparam logic [11:0] BANK0_BASE = 12'h000;
  localparam logic [11:0] BANK1_BASE = 12'h100;
  // register indices, byte address is base plus four times the index
  localparam logic [7:0] IDX_EVENT_FLAGS = 8'h16;
  localparam logic [7:0] IDX_EVENT_ENABLES = 8'h1d;
  localparam logic [7:0] IDX_DT_CONTROL = 8'h14;
  localparam logic [7:0] IDX_DT_LENGTH = 8'h15;
  localparam logic [7:0] IDX_PIN_SELECT = 8'h16;
  localparam logic [7:0] IDX_A_CONTROL = 8'h17;
  localparam logic [7:0] IDX_A_PERIOD_LOW = 8'h18;
  localparam logic [7:0] IDX_A_PERIOD_HIGH = 8'h19;
  localparam logic [7:0] IDX_A_DUTY_LOW = 8'h1a;
  localparam logic [7:0] IDX_A_DUTY_HIGH = 8'h1b;
  localparam logic [7:0] IDX_A_COUNT_LOW = 8'h1c;
  localparam logic [7:0] IDX_A_COUNT_HIGH = 8'h1d;
  localparam logic [7:0] IDX_B_CONTROL = 8'h1e;
  localparam logic [7:0] IDX_B_PERIOD_LOW = 8'h1f;
  localparam logic [7:0] IDX_B_PERIOD_HIGH = 8'h20;
  localparam logic [7:0] IDX_B_DUTY_LOW = 8'h21;
  localparam logic [7:0] IDX_B_DUTY_HIGH = 8'h22;
  localparam logic [7:0] IDX_B_COUNT_LOW = 8'h23;
  localparam logic [7:0] IDX_B_COUNT_HIGH = 8'h24;
  // channel control fields
  localparam int CTL_TRUE_EN = 7;
  localparam int CTL_INV_EN = 6;
  localparam int CTL_TRUE_LVL = 5;
  localparam int CTL_INV_LVL = 4;
  localparam int CTL_RUN = 3;
  localparam int CTL_PS_LSB = 0;
  // event flags: duty then period, channel a in the low pair
  localparam int FLAG_A_DUTY = 0;
  localparam int FLAG_A_PERIOD = 1;
  localparam int FLAG_B_DUTY = 2;
  localparam int FLAG_B_PERIOD = 3;
  localparam int DTC_PS_LSB = 0;
  localparam int DTC_A_EN = 2;
  localparam int DTC_B_EN = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PIN_SELECT_MASK = 8'h13;

  function automatic logic [11:0] reg_addr(input logic bank, input logic [7:0] idx);
    return (bank ? BANK1_BASE : BANK0_BASE) | {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [7:0] prescale_ratio(input logic [2:0] sel);
    return 8'h01 << sel;
  endfunction

  function automatic logic [7:0] dead_ratio(input logic [1:0] sel);
    return 8'h01 << sel;
  endfunction
endpackage

// *** verilog/pwm_channel.sv ***
// one pwm channel: prescaler, up-counter, duty latch and waveform
// assumes period and duty come straight from software registers
`timescale 1ns/1ps
module pwm_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] prescale_select,
  input wire logic [pwm_pkg::CNT_W-1:0] period_value,
  input wire logic [pwm_pkg::CNT_W-1:0] duty_value,
  output logic [pwm_pkg::CNT_W-1:0] channel_counter,
  output logic [pwm_pkg::CNT_W-1:0] duty_latch,
  output logic wave,
  output logic period_event,
  output logic duty_event
);
  import pwm_pkg::*;

  logic [7:0] pre_count;
  logic tick;
  logic matched;
  logic [CNT_W-1:0] next_count;

  assign tick = run && (pre_count >= prescale_ratio(prescale_select) - 8'h01);
  assign next_count = (channel_counter == period_value) ? '0 : channel_counter + 1'b1;

  // prescaler, held clear while stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_count <= 8'h00;
    end else if (!run || tick) begin
      pre_count <= 8'h00;
    end else begin
      pre_count <= pre_count + 8'h01;
    end
  end

  // counter, latch and waveform
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_counter <= '0;
      duty_latch <= '0;
      matched <= 1'b1;
      wave <= 1'b0;
      period_event <= 1'b0;
      duty_event <= 1'b0;
    end else begin
      period_event <= 1'b0;
      duty_event <= 1'b0;
      if (tick) begin
        channel_counter <= next_count;
        if (channel_counter == period_value) begin
          period_event <= 1'b1;
          if (matched || duty_latch == '0) begin
            duty_latch <= duty_value;
            matched <= (duty_value == '0);
            wave <= (duty_value != '0);
          end else begin
            wave <= (duty_latch != '0);
          end
        end else if (next_count == duty_latch && !matched) begin
          wave <= 1'b0;
          duty_event <= 1'b1;
          matched <= 1'b1;
        end
      end
    end
  end
endmodule // pwm_channel

// *** verilog/dead_time_gen.sv ***
// splits one waveform into complementary phases with an optional gap
// assumes the waveform input changes only on clock edges
`timescale 1ns/1ps
module dead_time_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dead_time_enable,
  input wire logic [1:0] dead_time_prescale,
  input wire logic [7:0] dead_time_count,
  input wire logic wave,
  output logic true_wave,
  output logic inv_wave
);
  import pwm_pkg::*;

  typedef enum logic [1:0] {DT_DRIVE = 2'b01, DT_GAP = 2'b10} dt_state_t;

  dt_state_t state;
  logic last;
  logic [15:0] gap;
  logic [15:0] gap_len;

  assign gap_len = 16'(dead_time_count) * 16'(dead_ratio(dead_time_prescale));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DT_DRIVE;
      last <= 1'b0;
      gap <= 16'h0000;
      true_wave <= 1'b0;
      inv_wave <= 1'b1;
    end else begin
      case (state)
        DT_DRIVE: begin
          last <= wave;
          if (wave != last && dead_time_enable && gap_len != 16'h0000) begin
            true_wave <= 1'b0;
            inv_wave <= 1'b0;
            gap <= gap_len;
            state <= DT_GAP;
          end else begin
            true_wave <= wave;
            inv_wave <= !wave;
          end
        end
        DT_GAP: begin
          last <= wave;
          if (!dead_time_enable || (wave == last && gap <= 16'h0001)) begin
            true_wave <= wave;
            inv_wave <= !wave;
            state <= DT_DRIVE;
          end else if (wave != last) begin
            gap <= gap_len;
          end else begin
            gap <= gap - 16'h0001;
          end
        end
        default: begin
          state <= DT_DRIVE;
        end
      endcase
    end
  end
endmodule // dead_time_gen

// *** verilog/dual_pwm.sv ***
// dual pwm top: apb register file, two channels, dead time and pins
// assumes an apb master on CLK; pins go to switches or loads
//
// Summary of operation
// - period and duty are ten bits each
// - ten-bit prescaled counter, readable, never writable
// - run bit starts counting, clearing it stops
// - period match clears counter, sets output, flag
// - zero latched duty keeps output inactive
// - period equals period plus one times prescale
// - prescale code zero counts every clock
// - duty latched at clear, match drops output
// - new duty waits until latched duty matched
// - high time equals duty times prescale
// - true and inverted pins enabled separately
// - both enabled gives waveform and its complement
// - dead time gap keeps both pins inactive
// - no dead time means simultaneous complementary edges
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module dual_pwm (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic PWM_IRQ,
  output logic CHAN_A_TRUE_OUTPUT,
  output logic CHAN_A_INVERTED_OUTPUT,
  output logic CHAN_B_TRUE_OUTPUT,
  output logic CHAN_B_INVERTED_OUTPUT
);
  import pwm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] event_flags;
  logic [3:0] event_enables;
  logic [3:0] dead_time_control;
  logic [7:0] dead_time_length;
  logic [7:0] pwm_pin_select;
  logic [7:0] chan_control [2];
  logic [CNT_W-1:0] period_value [2];
  logic [CNT_W-1:0] duty_value [2];
  logic [CNT_W-1:0] channel_counter [2];
  logic [CNT_W-1:0] duty_latch [2];
  logic [1:0] wave;
  logic [1:0] true_wave;
  logic [1:0] inv_wave;
  logic [1:0] period_event;
  logic [1:0] duty_event;
  logic [1:0] dead_en;
  logic [3:0] flag_set;
  logic [3:0] flag_clear;
  logic wr;
  logic setup;
  logic [31:0] rd_data;
  logic rd_hit;

  assign wr = PSEL && PENABLE && PWRITE;
  assign setup = PSEL && !PENABLE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !rd_hit;
  assign dead_en[0] = dead_time_control[DTC_A_EN];
  assign dead_en[1] = dead_time_control[DTC_B_EN];

  function automatic logic hit(input logic [11:0] a, input logic bank, input logic [7:0] idx);
    return a == reg_addr(bank, idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // address decode and read data
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR)
      reg_addr(1'b0, IDX_EVENT_FLAGS): rd_data[3:0] = event_flags;
      reg_addr(1'b0, IDX_EVENT_ENABLES): rd_data[3:0] = event_enables;
      reg_addr(1'b1, IDX_DT_CONTROL): rd_data[3:0] = dead_time_control;
      reg_addr(1'b1, IDX_DT_LENGTH): rd_data[7:0] = dead_time_length;
      reg_addr(1'b1, IDX_PIN_SELECT): rd_data[7:0] = pwm_pin_select;
      reg_addr(1'b1, IDX_A_CONTROL): rd_data[7:0] = chan_control[0];
      reg_addr(1'b1, IDX_A_PERIOD_LOW): rd_data[7:0] = period_value[0][7:0];
      reg_addr(1'b1, IDX_A_PERIOD_HIGH): rd_data[1:0] = period_value[0][9:8];
      reg_addr(1'b1, IDX_A_DUTY_LOW): rd_data[7:0] = duty_value[0][7:0];
      reg_addr(1'b1, IDX_A_DUTY_HIGH): rd_data[1:0] = duty_value[0][9:8];
      reg_addr(1'b1, IDX_A_COUNT_LOW): rd_data[7:0] = channel_counter[0][7:0];
      reg_addr(1'b1, IDX_A_COUNT_HIGH): rd_data[1:0] = channel_counter[0][9:8];
      reg_addr(1'b1, IDX_B_CONTROL): rd_data[7:0] = chan_control[1];
      reg_addr(1'b1, IDX_B_PERIOD_LOW): rd_data[7:0] = period_value[1][7:0];
      reg_addr(1'b1, IDX_B_PERIOD_HIGH): rd_data[1:0] = period_value[1][9:8];
      reg_addr(1'b1, IDX_B_DUTY_LOW): rd_data[7:0] = duty_value[1][7:0];
      reg_addr(1'b1, IDX_B_DUTY_HIGH): rd_data[1:0] = duty_value[1][9:8];
      reg_addr(1'b1, IDX_B_COUNT_LOW): rd_data[7:0] = channel_counter[1][7:0];
      reg_addr(1'b1, IDX_B_COUNT_HIGH): rd_data[1:0] = channel_counter[1][9:8];
      default: rd_hit = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      PRDATA <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared configuration registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      event_enables <= REG_RESET[3:0];
      dead_time_control <= REG_RESET[3:0];
      dead_time_length <= REG_RESET;
      pwm_pin_select <= REG_RESET;
    end else if (wr) begin
      if (hit(PADDR, 1'b0, IDX_EVENT_ENABLES)) begin
        event_enables <= PWDATA[3:0];
      end
      if (hit(PADDR, 1'b1, IDX_DT_CONTROL)) begin
        dead_time_control <= PWDATA[3:0];
      end
      if (hit(PADDR, 1'b1, IDX_DT_LENGTH)) begin
        dead_time_length <= PWDATA[7:0];
      end
      if (hit(PADDR, 1'b1, IDX_PIN_SELECT)) begin
        pwm_pin_select <= PWDATA[7:0] & PIN_SELECT_MASK;
      end
    end
  end

  // channel a registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      chan_control[0] <= REG_RESET;
      period_value[0] <= '0;
      duty_value[0] <= '0;
    end else if (wr) begin
      if (hit(PADDR, 1'b1, IDX_A_CONTROL)) begin
        chan_control[0] <= PWDATA[7:0];
      end
      if (hit(PADDR, 1'b1, IDX_A_PERIOD_LOW)) begin
        period_value[0][7:0] <= PWDATA[7:0];
      end
      if (hit(PADDR, 1'b1, IDX_A_PERIOD_HIGH)) begin
        period_value[0][9:8] <= PWDATA[1:0];
      end
      if (hit(PADDR, 1'b1, IDX_A_DUTY_LOW)) begin
        duty_value[0][7:0] <= PWDATA[7:0];
      end
      if (hit(PADDR, 1'b1, IDX_A_DUTY_HIGH)) begin
        duty_value[0][9:8] <= PWDATA[1:0];
      end
    end
  end

  // channel b registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      chan_control[1] <= REG_RESET;
      period_value[1] <= '0;
      duty_value[1] <= '0;
    end else if (wr) begin
      if (hit(PADDR, 1'b1, IDX_B_CONTROL)) begin
        chan_control[1] <= PWDATA[7:0];
      end
      if (hit(PADDR, 1'b1, IDX_B_PERIOD_LOW)) begin
        period_value[1][7:0] <= PWDATA[7:0];
      end
      if (hit(PADDR, 1'b1, IDX_B_PERIOD_HIGH)) begin
        period_value[1][9:8] <= PWDATA[1:0];
      end
      if (hit(PADDR, 1'b1, IDX_B_DUTY_LOW)) begin
        duty_value[1][7:0] <= PWDATA[7:0];
      end
      if (hit(PADDR, 1'b1, IDX_B_DUTY_HIGH)) begin
        duty_value[1][9:8] <= PWDATA[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event flags, write one to clear, a new event wins
  assign flag_set[FLAG_A_DUTY] = duty_event[0];
  assign flag_set[FLAG_A_PERIOD] = period_event[0];
  assign flag_set[FLAG_B_DUTY] = duty_event[1];
  assign flag_set[FLAG_B_PERIOD] = period_event[1];
  assign flag_clear = (wr && hit(PADDR, 1'b0, IDX_EVENT_FLAGS)) ? PWDATA[3:0] : 4'h0;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      event_flags <= REG_RESET[3:0];
    end else begin
      event_flags <= (event_flags & ~flag_clear) | flag_set;
    end
  end

  assign PWM_IRQ = |(event_flags & event_enables);

  ////////////////////////////////////////////////////////////////////////////////
  // channels and dead time
  for (genvar c = 0; c < 2; c++) begin : g_chan
    pwm_channel u_channel (
      .clk(CLK),
      .rst_n(RESET_N),
      .run(chan_control[c][CTL_RUN]),
      .prescale_select(chan_control[c][CTL_PS_LSB +: 3]),
      .period_value(period_value[c]),
      .duty_value(duty_value[c]),
      .channel_counter(channel_counter[c]),
      .duty_latch(duty_latch[c]),
      .wave(wave[c]),
      .period_event(period_event[c]),
      .duty_event(duty_event[c])
    );

    dead_time_gen u_dead (
      .clk(CLK),
      .rst_n(RESET_N),
      .dead_time_enable(dead_en[c]),
      .dead_time_prescale(dead_time_control[DTC_PS_LSB +: 2]),
      .dead_time_count(dead_time_length),
      .wave(wave[c]),
      .true_wave(true_wave[c]),
      .inv_wave(inv_wave[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output pins: enable gates, active level inverts
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CHAN_A_TRUE_OUTPUT <= 1'b0;
      CHAN_A_INVERTED_OUTPUT <= 1'b0;
      CHAN_B_TRUE_OUTPUT <= 1'b0;
      CHAN_B_INVERTED_OUTPUT <= 1'b0;
    end else begin
      CHAN_A_TRUE_OUTPUT <= chan_control[0][CTL_TRUE_EN] &&
                            (true_wave[0] ^ chan_control[0][CTL_TRUE_LVL]);
      CHAN_A_INVERTED_OUTPUT <= chan_control[0][CTL_INV_EN] &&
                                (inv_wave[0] ^ chan_control[0][CTL_INV_LVL]);
      CHAN_B_TRUE_OUTPUT <= chan_control[1][CTL_TRUE_EN] &&
                            (true_wave[1] ^ chan_control[1][CTL_TRUE_LVL]);
      CHAN_B_INVERTED_OUTPUT <= chan_control[1][CTL_INV_EN] &&
                                (inv_wave[1] ^ chan_control[1][CTL_INV_LVL]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks on channel a
  sequence s_period_hit;
    $past(channel_counter[0]) == $past(period_value[0]) &&
      channel_counter[0] != $past(channel_counter[0]);
  endsequence

  property p_counter_wraps;
    @(posedge CLK) disable iff (!RESET_N)
      s_period_hit |-> channel_counter[0] == '0;
  endproperty
  a_counter_wraps: assert property (p_counter_wraps)
    else $error("counter did not clear after period match");

  property p_stopped_holds;
    @(posedge CLK) disable iff (!RESET_N)
      !chan_control[0][CTL_RUN] && $past(!chan_control[0][CTL_RUN])
        |-> $stable(channel_counter[0]);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("counter moved while stopped");

  property p_full_rate;
    @(posedge CLK) disable iff (!RESET_N)
      chan_control[0][CTL_RUN] && $past(chan_control[0][CTL_RUN]) &&
      chan_control[0][2:0] == 3'h0 && $past(chan_control[0][2:0]) == 3'h0 &&
      period_value[0] != '0 && $stable(period_value[0])
        |-> channel_counter[0] != $past(channel_counter[0]);
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("counter did not advance at ratio one");

  property p_period_sets_output;
    @(posedge CLK) disable iff (!RESET_N)
      period_event[0] |-> (wave[0] == (duty_latch[0] != '0)) && channel_counter[0] == '0;
  endproperty
  a_period_sets_output: assert property (p_period_sets_output)
    else $error("output level wrong at period start");

  property p_duty_clears;
    @(posedge CLK) disable iff (!RESET_N)
      channel_counter[0] == duty_latch[0] |-> !wave[0];
  endproperty
  a_duty_clears: assert property (p_duty_clears)
    else $error("output active at duty match");

  property p_latch_at_clear;
    @(posedge CLK) disable iff (!RESET_N)
      $changed(duty_latch[0]) |-> channel_counter[0] == '0 && period_event[0];
  endproperty
  a_latch_at_clear: assert property (p_latch_at_clear)
    else $error("duty latch changed outside counter clear");

  sequence s_flag_event;
    (period_event[0] && event_enables[FLAG_A_PERIOD]) ||
      (duty_event[0] && event_enables[FLAG_A_DUTY]);
  endsequence

  property p_irq_follows;
    @(posedge CLK) disable iff (!RESET_N)
      s_flag_event |=> PWM_IRQ;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("enabled event did not raise interrupt");

  property p_no_overlap;
    @(posedge CLK) disable iff (!RESET_N)
      dead_en[0] |-> !(true_wave[0] && inv_wave[0]);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("complementary phases overlap");

  property p_gap_inserted;
    @(posedge CLK) disable iff (!RESET_N)
      dead_en[0] && dead_time_length != 8'h00 && $changed(wave[0])
        |=> !true_wave[0] && !inv_wave[0];
  endproperty
  a_gap_inserted: assert property (p_gap_inserted)
    else $error("no gap after waveform edge");

  property p_plain_complement;
    @(posedge CLK) disable iff (!RESET_N)
      !dead_en[0] && $past(!dead_en[0]) |-> inv_wave[0] == !true_wave[0];
  endproperty
  a_plain_complement: assert property (p_plain_complement)
    else $error("phases not complementary without dead time");

  property p_pin_level;
    @(posedge CLK) disable iff (!RESET_N)
      chan_control[0][CTL_TRUE_EN] |=>
        CHAN_A_TRUE_OUTPUT == ($past(true_wave[0]) ^ $past(chan_control[0][CTL_TRUE_LVL]));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("true pin level wrong");

  property p_pin_off;
    @(posedge CLK) disable iff (!RESET_N)
      !chan_control[0][CTL_INV_EN] |=> !CHAN_A_INVERTED_OUTPUT;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("disabled inverted pin driven");
endmodule // dual_pwm

// *** verification/pwm_load.sv ***
// load model: a half bridge on the channel a true and inverted pins
// assumes both pins are high-active and sampled on the falling clock edge
`timescale 1ns/1ps
module pwm_load (
  input wire logic clk,
  input wire logic upper_on,
  input wire logic lower_on,
  output int shoot_through
);
  ////////////////////////////////////////////////////////////////////////
  // both switches on at once is a short
  initial begin
    shoot_through = 0;
    forever begin
      @(negedge clk);
      if (upper_on === 1'b1 && lower_on === 1'b1) begin
        shoot_through++;
      end
    end
  end
endmodule // pwm_load

// *** verification/tb_dual_pwm.sv ***
// testbench for the dual pwm block: apb tasks and pin measurements
// assumes a zero wait apb slave and the pwm_load model on channel a
`timescale 1ns/1ps
module tb_dual_pwm;
  import pwm_pkg::*;
  logic clk, reset_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, irq, a_t, a_i, b_t, b_i;
  logic [3:0] pins;
  logic [31:0] rd;
  int mismatches, n_tests, shoot, hi, per, n;
  logic [7:0] tp[3], td[3], tps[3];
  assign pins = {b_i, b_t, a_i, a_t};
  dual_pwm uut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PWM_IRQ(irq), .CHAN_A_TRUE_OUTPUT(a_t),
    .CHAN_A_INVERTED_OUTPUT(a_i), .CHAN_B_TRUE_OUTPUT(b_t), .CHAN_B_INVERTED_OUTPUT(b_i));
  pwm_load load (.clk(clk), .upper_on(a_t), .lower_on(a_i), .shoot_through(shoot));
  ////////////////////////////////////////////////////////////////////////
  // apb master and helpers
  function automatic logic [11:0] ad(input logic [7:0] i);
    return 12'h100 | {2'b00, i, 2'b00};
  endfunction
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    n = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rdchk(input string s, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk(s, e, rd);
  endtask
  task automatic cfg(input logic [7:0] p, d, ctl, dtc, dtl);
    wr(ad(IDX_A_CONTROL), 8'h00);
    wr(ad(IDX_DT_LENGTH), dtl);
    wr(ad(IDX_DT_CONTROL), dtc);
    wr(ad(IDX_A_PERIOD_LOW), p);
    wr(ad(IDX_A_PERIOD_HIGH), 8'h00);
    wr(ad(IDX_A_DUTY_LOW), d);
    wr(ad(IDX_A_DUTY_HIGH), 8'h00);
    wr(ad(IDX_A_CONTROL), ctl);
    wr(ad(IDX_A_CONTROL), ctl | 8'h08);
  endtask
  task automatic meas(input int p);
    int k;
    k = 0;
    while (pins[p] !== 1'b0 && k < 300) begin @(negedge clk); k++; end
    while (pins[p] !== 1'b1 && k < 600) begin @(negedge clk); k++; end
    hi = 0;
    while (pins[p] === 1'b1 && k < 900) begin @(negedge clk); hi++; k++; end
    per = hi;
    while (pins[p] === 1'b0 && k < 1200) begin @(negedge clk); per++; k++; end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock, reset, watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    summarize;
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    n_tests = 0;
    tp = '{8'h03, 8'h05, 8'h06};
    td = '{8'h01, 8'h02, 8'h02};
    tps = '{8'h00, 8'h01, 8'h03};
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rdchk("a_control reset", ad(IDX_A_CONTROL), 32'h0);
    rdchk("dt_length reset", ad(IDX_DT_LENGTH), 32'h0);
    rdchk("flags reset", {2'b00, IDX_EVENT_FLAGS, 2'b00}, 32'h0);
    rdchk("unmapped data", 12'h0fc, 32'h0);
    chk("unmapped error", 32'h1, n);
    wr({2'b00, IDX_EVENT_ENABLES, 2'b00}, 8'h03);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      cfg(tp[i], td[i], 8'hc0 | tps[i], 8'h00, 8'h00);
      meas(0);
      meas(0);
      chk("high time", td[i] << tps[i], hi);
      chk("period", (tp[i] + 1) << tps[i], per);
      n = 0;
      repeat (40) begin @(negedge clk); n += (a_i !== ~a_t); end
      chk("complement", 0, n);
    end
    $display("test timing done");
    cfg(8'h09, 8'h05, 8'hc0, (8'h01 << DTC_A_EN) | 8'h01, 8'h01);
    meas(0);
    meas(0);
    chk("dead true high", 3, hi);
    chk("dead period", 10, per);
    meas(1);
    chk("dead inv high", 3, hi);
    $display("test dead time done");
    cfg(8'h09, 8'h03, 8'ha0, 8'h00, 8'h00);
    meas(0);
    meas(0);
    chk("level high", 7, hi);
    chk("inv disabled", 1'b0, a_i);
    cfg(8'h09, 8'h00, 8'h80, 8'h00, 8'h00);
    repeat (30) @(negedge clk);
    n = 0;
    repeat (30) begin @(negedge clk); n += (a_t !== 1'b0); end
    chk("zero duty", 0, n);
    $display("test levels done");
    wr(ad(IDX_A_CONTROL), 8'h00);
    xfer(1'b0, ad(IDX_A_COUNT_LOW), 8'h00);
    per = rd;
    repeat (5) @(posedge clk);
    wr(ad(IDX_A_COUNT_LOW), 8'hff);
    rdchk("count frozen", ad(IDX_A_COUNT_LOW), per);
    rdchk("flags set", {2'b00, IDX_EVENT_FLAGS, 2'b00}, 32'h3);
    wr({2'b00, IDX_EVENT_ENABLES, 2'b00}, 8'h02);
    @(negedge clk);
    chk("irq period", 1'b1, irq);
    wr({2'b00, IDX_EVENT_FLAGS, 2'b00}, 8'h02);
    @(negedge clk);
    chk("irq masked", 1'b0, irq);
    rdchk("flag left", {2'b00, IDX_EVENT_FLAGS, 2'b00}, 32'h1);
    wr({2'b00, IDX_EVENT_ENABLES, 2'b00}, 8'h01);
    @(negedge clk);
    chk("irq duty", 1'b1, irq);
    wr({2'b00, IDX_EVENT_FLAGS, 2'b00}, 8'h01);
    @(negedge clk);
    chk("irq cleared", 1'b0, irq);
    chk("overlap", 0, shoot);
    $display("test flags done");
    wr(ad(IDX_B_PERIOD_LOW), 8'h03);
    wr(ad(IDX_B_DUTY_LOW), 8'h01);
    wr(ad(IDX_B_CONTROL), 8'hd8);
    meas(2);
    meas(2);
    chk("b high", 1, hi);
    chk("b period", 4, per);
    meas(3);
    chk("b inv level", 1, hi);
    chk("b inv period", 4, per);
    rdchk("b flags", {2'b00, IDX_EVENT_FLAGS, 2'b00}, 32'hc);
    $display("test channel b done");
    summarize;
  end
endmodule // tb_dual_pwm
